// ===== logic/uglyph_pkg.sv
// constants for the user glyph RAM and its lookup path
package uglyph_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int DOTS_W = 5;
  localparam int ROW_W = 3;
  localparam int IDX_W = 3;
  localparam int DEPTH = 64;
  localparam int GLYPHS_5X8 = 8;
  localparam int GLYPHS_5X10 = 4;
  localparam logic [2:0] CURSOR_ROW = 3'h7;
  localparam logic [7:0] RAM_RESET = 8'h00;
  localparam logic [4:0] DOTS_DARK = 5'h00;
  localparam logic [5:0] PTR_RESET = 6'h00;
  localparam logic [3:0] USER_CODE_HI = 4'h0;
endpackage : uglyph_pkg

// ===== logic/uglyph_row_sel.sv
// glyph address former: code bits and scan row into a RAM address
`timescale 1ns/1ps
module uglyph_row_sel (
  input wire logic [7:0] code, // character code from the text RAM
  input wire logic [2:0] row, // scan row counter
  output logic [5:0] addr, // glyph RAM read address
  output logic is_user // code selects a user glyph
);
  // code bit 3 is dropped, so 00H and 08H alias
  assign addr = {code[2:0], row};
  assign is_user = (code[7:4] == uglyph_pkg::USER_CODE_HI);
endmodule : uglyph_row_sel

// ===== logic/uglyph_top.sv
// user glyph RAM with host write/read port, auto-stepping pointer and scan lookup
`timescale 1ns/1ps
module uglyph_top #(
  parameter int DATA_W = uglyph_pkg::DATA_W, // bits per stored glyph byte and per character code
  parameter int ADDR_W = uglyph_pkg::ADDR_W, // glyph RAM address and pointer width
  parameter int DOTS_W = uglyph_pkg::DOTS_W, // dots per pixel row
  parameter int ROW_W = uglyph_pkg::ROW_W, // scan row counter width
  parameter int DEPTH = uglyph_pkg::DEPTH // glyph RAM bytes
) (
  input wire logic CLOCK, // 20 MHz system clock
  input wire logic NRST, // asynchronous reset, active low
  input wire logic SET_PTR, // load the address pointer, one-cycle pulse
  input wire logic [ADDR_W-1:0] PTR_VALUE, // new address pointer value
  input wire logic WR_STB, // host data write strobe, one-cycle pulse
  input wire logic [DATA_W-1:0] WR_DATA, // host data byte
  input wire logic RD_STB, // host data read strobe, one-cycle pulse
  input wire logic INC_MODE, // entry mode: 1 steps up, 0 steps down
  input wire logic [DATA_W-1:0] SCAN_CODE, // character code at the scanned position
  input wire logic [ROW_W-1:0] SCAN_ROW, // scan row counter
  input wire logic [DOTS_W-1:0] CURSOR_DOTS, // cursor pattern for the cursor row
  output logic [DATA_W-1:0] RD_DATA, // byte read by the host
  output logic RD_VALID, // read data valid, one-cycle pulse
  output logic [ADDR_W-1:0] PTR_OUT, // current address pointer
  output logic [DOTS_W-1:0] ROW_DOTS, // pixel row, bit 4 leftmost
  output logic ROW_USER // row came from the user glyph RAM
);

  // a single pointer step, sized to the pointer
  localparam logic [ADDR_W-1:0] PTR_ONE = {{(ADDR_W-1){1'h0}}, 1'h1};

  // host access kinds: idle, then load, write and read from highest priority down
  typedef enum {
    HOST_IDLE,
    HOST_LOAD,
    HOST_WRITE,
    HOST_READ
  } uglyph_op_t;

  uglyph_op_t host_op;
  // eight rows of five dots per glyph: the 64 bytes hold eight 5x8 glyphs, addressed by code bits 2:0 and the scan row
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [DATA_W-1:0] mem_d [DEPTH];
  logic [ADDR_W-1:0] ptr_q;
  logic [ADDR_W-1:0] ptr_d;
  logic [ADDR_W-1:0] ptr_step;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic rd_valid_q;
  logic rd_valid_d;
  logic [DOTS_W-1:0] dots_q;
  logic [DOTS_W-1:0] dots_d;
  logic user_q;
  logic user_d;
  logic [ADDR_W-1:0] scan_addr;
  logic scan_user;
  logic scan_cursor;
  logic [DATA_W-1:0] scan_byte;
  logic [DOTS_W-1:0] row_bits;

  uglyph_row_sel u_sel (
    .code(SCAN_CODE),
    .row(SCAN_ROW),
    .addr(scan_addr),
    .is_user(scan_user)
  );

  // load beats write beats read; a losing strobe in the same cycle is dropped without notice
  always_comb begin
    if (SET_PTR) begin
      host_op = HOST_LOAD;
    end else if (WR_STB) begin
      host_op = HOST_WRITE;
    end else if (RD_STB) begin
      host_op = HOST_READ;
    end else begin
      host_op = HOST_IDLE;
    end
  end

  // the pointer wraps modulo the RAM size in both directions
  always_comb begin
    if (INC_MODE) begin
      ptr_step = ptr_q + PTR_ONE;
    end else begin
      ptr_step = ptr_q - PTR_ONE;
    end
  end

  always_comb begin
    ptr_d = ptr_q;
    case (host_op)
      HOST_LOAD: begin
        ptr_d = PTR_VALUE;
      end
      HOST_WRITE: begin
        ptr_d = ptr_step;
      end
      HOST_READ: begin
        ptr_d = ptr_step;
      end
      default: begin
        ptr_d = ptr_q;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ptr_q <= uglyph_pkg::PTR_RESET;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // the write port never waits for the scan, so a glyph may be rewritten while it is on show
  always_comb begin
    mem_d = mem_q;
    case (host_op)
      HOST_WRITE: begin
        mem_d[ptr_q] = WR_DATA;
      end
      default: begin
        mem_d = mem_q;
      end
    endcase
  end

  // clearing every byte costs reset fan-out, but a fresh glyph RAM then shows blank
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= uglyph_pkg::RAM_RESET;
      end
    end else begin
      mem_q <= mem_d;
    end
  end

  // read data holds until the next read, so a slow host may pick it up late
  always_comb begin
    rd_data_d = rd_data_q;
    rd_valid_d = 1'h0;
    case (host_op)
      HOST_READ: begin
        rd_data_d = mem_q[ptr_q];
        rd_valid_d = 1'h1;
      end
      default: begin
        rd_data_d = rd_data_q;
        rd_valid_d = 1'h0;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rd_data_q <= uglyph_pkg::RAM_RESET;
      rd_valid_q <= 1'h0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // scan reads the registered RAM, so a byte written in this cycle shows from the next scan on
  assign scan_byte = mem_q[scan_addr];
  assign row_bits = scan_byte[DOTS_W-1:0];
  assign scan_cursor = (SCAN_ROW == uglyph_pkg::CURSOR_ROW);

  // the flag is registered beside the dots so both outputs belong to one scan sample
  always_comb begin
    user_d = scan_user;
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      user_q <= 1'h0;
    end else begin
      user_q <= user_d;
    end
  end

  // codes outside the user range show dark here; the fixed font is merged elsewhere
  always_comb begin
    dots_d = uglyph_pkg::DOTS_DARK;
    if (scan_user) begin
      if (scan_cursor) begin
        // stored ones stay lit even without the cursor here
        dots_d = row_bits | CURSOR_DOTS;
      end else begin
        dots_d = row_bits;
      end
    end else begin
      dots_d = uglyph_pkg::DOTS_DARK;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      dots_q <= uglyph_pkg::DOTS_DARK;
    end else begin
      dots_q <= dots_d;
    end
  end

  // every output is a register, so the scan multiplexer never glitches the pins
  assign RD_DATA = rd_data_q;
  assign RD_VALID = rd_valid_q;
  assign PTR_OUT = ptr_q;
  assign ROW_DOTS = dots_q;
  assign ROW_USER = user_q;

endmodule : uglyph_top

// ===== testbench/uglyph_assertions.sv
// assertions on the host strobe, pointer and glyph lookup ports
`timescale 1ns/1ps
module uglyph_assertions (
  input wire logic CLOCK, // system clock
  input wire logic NRST, // reset, active low
  input wire logic SET_PTR, // pointer load strobe
  input wire logic WR_STB, // write strobe
  input wire logic RD_STB, // read strobe
  input wire logic INC_MODE, // step direction
  input wire logic RD_VALID, // read data valid
  input wire logic ROW_USER, // row from the user glyph RAM
  input wire logic [5:0] PTR_VALUE, // pointer load value
  input wire logic [5:0] PTR_OUT, // current pointer
  input wire logic [7:0] SCAN_CODE, // scanned code
  input wire logic [2:0] SCAN_ROW, // scan row
  input wire logic [4:0] CURSOR_DOTS, // cursor pattern
  input wire logic [4:0] ROW_DOTS // pixel row
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  sequence s_rd; RD_STB && !SET_PTR && !WR_STB; endsequence
  sequence s_cur; SCAN_ROW == 3'h7 && SCAN_CODE[7:4] == 4'h0; endsequence
  AST_USER: assert property ($past(NRST) |-> ROW_USER == ($past(SCAN_CODE[7:4]) == 4'h0)) else $error("user");
  AST_ZERO: assert property (!ROW_USER |-> ROW_DOTS == 5'h00) else $error("dots");
  AST_RD: assert property (s_rd |=> RD_VALID) else $error("rd");
  AST_NORD: assert property (!RD_STB |=> !RD_VALID) else $error("nord");
  AST_STEP: assert property ((WR_STB || RD_STB) && !SET_PTR |=>
    PTR_OUT == $past(PTR_OUT) + ($past(INC_MODE) ? 6'h01 : 6'h3F)) else $error("step");
  AST_LOAD: assert property (SET_PTR |=> PTR_OUT == $past(PTR_VALUE)) else $error("load");
  AST_HOLD: assert property (!(SET_PTR || WR_STB || RD_STB) |=> $stable(PTR_OUT)) else $error("hold");
  AST_CUR: assert property (s_cur |=> (ROW_DOTS | $past(CURSOR_DOTS)) == ROW_DOTS) else $error("cur");
endmodule : uglyph_assertions
bind uglyph_top uglyph_assertions i_chk (
  .CLOCK(CLOCK),
  .NRST(NRST),
  .SET_PTR(SET_PTR),
  .WR_STB(WR_STB),
  .RD_STB(RD_STB),
  .INC_MODE(INC_MODE),
  .RD_VALID(RD_VALID),
  .ROW_USER(ROW_USER),
  .PTR_VALUE(PTR_VALUE),
  .PTR_OUT(PTR_OUT),
  .SCAN_CODE(SCAN_CODE),
  .SCAN_ROW(SCAN_ROW),
  .CURSOR_DOTS(CURSOR_DOTS),
  .ROW_DOTS(ROW_DOTS)
);

// ===== testbench/uglyph_host.sv
// host model driving the glyph RAM strobes
`timescale 1ns/1ps
module uglyph_host (
  input wire logic CLOCK, // system clock
  output logic SET_PTR = 1'h0, // pointer load strobe
  output logic WR_STB = 1'h0, // write strobe
  output logic RD_STB = 1'h0, // read strobe
  output logic INC_MODE = 1'h1, // step direction
  output logic [5:0] PTR_VALUE = 6'h00, // pointer value
  output logic [7:0] WR_DATA = 8'h00 // data byte; row 7 should be zero
);
  task op(input logic s, w, r, i, input logic [7:0] d);
    @(posedge CLOCK) #1 {SET_PTR, WR_STB, RD_STB, INC_MODE, PTR_VALUE, WR_DATA} = {s, w, r, i, d[5:0], d};
    @(posedge CLOCK) #1 {SET_PTR, WR_STB, RD_STB} = 3'h0;
  endtask : op
endmodule : uglyph_host

// ===== testbench/tb_uglyph_top.sv
// self-checking bench for the user glyph RAM lookup
`timescale 1ns/1ps
module tb_uglyph_top;
  logic CLOCK = 1'h0, NRST = 1'h0, SET_PTR, WR_STB, RD_STB, INC_MODE, RD_VALID, ROW_USER;
  logic [5:0] PTR_VALUE, PTR_OUT;
  logic [7:0] WR_DATA, RD_DATA, SCAN_CODE = 8'h00;
  logic [2:0] SCAN_ROW = 3'h0;
  logic [4:0] CURSOR_DOTS = 5'h00, ROW_DOTS;
  int errors = 0, n_tests = 0, cyc = 0;
  always #25 CLOCK = ~CLOCK;
  uglyph_host i_host (.CLOCK, .SET_PTR, .WR_STB, .RD_STB, .INC_MODE, .PTR_VALUE, .WR_DATA);
  uglyph_top i_dut (
    .CLOCK(CLOCK),
    .NRST(NRST),
    .SET_PTR(SET_PTR),
    .PTR_VALUE(PTR_VALUE),
    .WR_STB(WR_STB),
    .WR_DATA(WR_DATA),
    .RD_STB(RD_STB),
    .INC_MODE(INC_MODE),
    .SCAN_CODE(SCAN_CODE),
    .SCAN_ROW(SCAN_ROW),
    .CURSOR_DOTS(CURSOR_DOTS),
    .RD_DATA(RD_DATA),
    .RD_VALID(RD_VALID),
    .PTR_OUT(PTR_OUT),
    .ROW_DOTS(ROW_DOTS),
    .ROW_USER(ROW_USER)
  );
  task chk(input string nm, input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // bits 7:5 set on rows 0 to 6 so any leak into the pixels shows
  function logic [7:0] pat(input int r);
    return r == 7 ? 8'h01 : {3'h7, 5'(r * 3 + 1)};
  endfunction : pat
  task t_fill;
    i_host.op(1'h1, 1'h0, 1'h0, 1'h0, 8'h07);
    for (int r = 7; r >= 0; r--) i_host.op(1'h0, 1'h1, 1'h0, 1'h0, pat(r));
    chk("ptr_wrap", PTR_OUT, 8'h3F);
    i_host.op(1'h1, 1'h0, 1'h0, 1'h1, 8'h06);
    for (int r = 6; r < 8; r++) begin
      i_host.op(1'h0, 1'h0, 1'h1, 1'h1, 8'h00);
      chk("rd_data", RD_DATA, pat(r));
      chk("rd_valid", RD_VALID, 1'h1);
    end
    chk("ptr_up", PTR_OUT, 8'h08);
    $display("t_fill done");
  endtask : t_fill
  // code 08 must reach glyph 0 as bit 3 is ignored; 18 must not
  task t_scan;
    for (int r = 0; r < 9; r++) begin
      @(posedge CLOCK) #1 {SCAN_CODE, SCAN_ROW, CURSOR_DOTS} = {r < 8 ? 8'h08 : 8'h18, 3'(r), 5'h10};
      @(posedge CLOCK) #1;
      chk("dots", ROW_DOTS, r > 7 ? 8'h00 : r == 7 ? 8'h11 : pat(r) & 8'h1F);
      chk("user", ROW_USER, r < 8);
    end
    $display("t_scan done");
  endtask : t_scan
  // glyph 5 rows: bits 7 and 5 set, cursor row kept clear as the host should
  function logic [7:0] gpat(input int r);
    return r == 7 ? 8'h00 : {3'h5, 5'h1A ^ 5'(r)};
  endfunction : gpat
  task scan(input logic [7:0] cd, input logic [2:0] rw, input logic [4:0] cur);
    @(posedge CLOCK) #1 {SCAN_CODE, SCAN_ROW, CURSOR_DOTS} = {cd, rw, cur};
    @(posedge CLOCK) #1;
  endtask : scan
  // a glyph other than 0 proves the code bits reach the upper address bits
  task t_glyph;
    i_host.op(1'h1, 1'h0, 1'h0, 1'h1, 8'h28);
    for (int r = 0; r < 8; r++) i_host.op(1'h0, 1'h1, 1'h0, 1'h1, gpat(r));
    chk("ptr_glyph", PTR_OUT, 8'h30);
    for (int r = 0; r < 8; r++) begin
      scan(r % 2 == 1 ? 8'h0D : 8'h05, 3'(r), 5'h00);
      chk("glyph5", ROW_DOTS, gpat(r) & 8'h1F);
    end
    scan(8'h05, 3'h7, 5'h1F);
    chk("cursor_on", ROW_DOTS, 8'h1F);
    scan(8'h00, 3'h7, 5'h00);
    chk("row7_lit", ROW_DOTS, 8'h01);
    scan(8'h80, 3'h2, 5'h1F);
    chk("rom_dots", ROW_DOTS, 8'h00);
    chk("rom_user", ROW_USER, 8'h00);
    $display("t_glyph done");
  endtask : t_glyph
  initial begin
    repeat (20) @(posedge CLOCK);
    #1 NRST = 1'h1;
    t_fill;
    t_scan;
    t_glyph;
    stop_test;
  end
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      stop_test;
    end
  end
endmodule : tb_uglyph_top
